// file: shared/mpus_pkg.sv
package mpus_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned MPUS_CLK_MHZ         = 200;
	localparam int unsigned MPUS_DEBOUNCE_US     = 10000;
	localparam int unsigned MPUS_DEBOUNCE_CYCLES = MPUS_DEBOUNCE_US * MPUS_CLK_MHZ;
	localparam int unsigned MPUS_SETTLE_US       = 1000;
	localparam int unsigned MPUS_SETTLE_CYCLES   = MPUS_SETTLE_US * MPUS_CLK_MHZ;
	localparam int          MPUS_CNT_W           = 24;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MPUS_ST_OFF,
		MPUS_ST_SUPPLY_UP,
		MPUS_ST_SOFT_OFF,
		MPUS_ST_CARRIER_ON,
		MPUS_ST_RUN,
		MPUS_ST_SUSPEND
	} mpus_state_t;

	// ----------------------------------------------------------------
	// Board signals
	// ----------------------------------------------------------------
	typedef struct packed {
		logic input_power_fault_n;
		logic supplies_good;
		logic reset_request_n;
		logic suspend_to_ram_n;
		logic auto_power_on;
	} mpus_board_in_t;

	typedef struct packed {
		logic internal_supply_enable;
		logic carrier_supply_enable;
		logic carrier_standby_n;
		logic module_reset_n;
	} mpus_pins_t;

	localparam mpus_pins_t MPUS_PINS_RESET = '{1'h0, 1'h0, 1'h1, 1'h0};

endpackage

// file: hw/mpus_button_filter.sv
module mpus_button_filter
	import mpus_pkg::*;
#(
	parameter int unsigned DEBOUNCE_CYCLES = MPUS_DEBOUNCE_CYCLES
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic power_button_n,
	output logic      press_event
);

	logic [MPUS_CNT_W-1:0] cnt_ff;
	logic [MPUS_CNT_W-1:0] nxt_cnt;
	logic                  pressed_ff;
	logic                  nxt_pressed;
	logic                  event_ff;
	logic                  nxt_event;

	// ----------------------------------------------------------------
	// Debounce
	// ----------------------------------------------------------------
	// A new level must stand for the whole window; contact bounce restarts it
	always_comb begin
		nxt_cnt     = cnt_ff;
		nxt_pressed = pressed_ff;
		nxt_event   = 1'h0;
		if (!power_button_n == pressed_ff) begin
			nxt_cnt = '0;
		end else if (cnt_ff == MPUS_CNT_W'(DEBOUNCE_CYCLES - 1)) begin
			nxt_cnt     = '0;
			nxt_pressed = !pressed_ff;
			nxt_event   = !pressed_ff;
		end else begin
			nxt_cnt = cnt_ff + MPUS_CNT_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_ff     <= '0;
			pressed_ff <= 1'h0;
			event_ff   <= 1'h0;
		end else begin
			cnt_ff     <= nxt_cnt;
			pressed_ff <= nxt_pressed;
			event_ff   <= nxt_event;
		end
	end

	assign press_event = event_ff;

	a_press_one_cycle: assert property (@(posedge clk) disable iff (rst)
		press_event |=> !press_event)
		else $error("press event longer than one cycle");

endmodule // mpus_button_filter

// file: hw/mpus_sequencer.sv
module mpus_sequencer
	import mpus_pkg::*;
#(
	parameter int unsigned DEBOUNCE_CYCLES = MPUS_DEBOUNCE_CYCLES,
	parameter int unsigned SETTLE_CYCLES   = MPUS_SETTLE_CYCLES
) (
	input  wire logic           clk,
	input  wire logic           rst,
	input  wire mpus_board_in_t board_in,
	input  wire logic           power_button_n,
	output mpus_pins_t          pins
);

	mpus_state_t           state_ff;
	mpus_state_t           nxt_state;
	logic [MPUS_CNT_W-1:0] cnt_ff;
	logic [MPUS_CNT_W-1:0] nxt_cnt;
	mpus_pins_t            pins_ff;
	mpus_pins_t            nxt_pins;
	logic                  press_event;
	logic [MPUS_CNT_W-1:0] settle_seen_ff;
	logic [MPUS_CNT_W-1:0] nxt_settle_seen;

	// ----------------------------------------------------------------
	// Power button
	// ----------------------------------------------------------------
	mpus_button_filter #(
		.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
	) u_button (
		.clk           (clk),
		.rst           (rst),
		.power_button_n(power_button_n),
		.press_event   (press_event)
	);

	// ----------------------------------------------------------------
	// Pin levels per state
	// ----------------------------------------------------------------
	function automatic mpus_pins_t pins_for(input mpus_state_t s);
		mpus_pins_t p;
		p = MPUS_PINS_RESET;
		unique case (s)
			MPUS_ST_OFF: begin
				p = MPUS_PINS_RESET;
			end
			MPUS_ST_SUPPLY_UP, MPUS_ST_SOFT_OFF: begin
				p.internal_supply_enable = 1'h1;
			end
			MPUS_ST_CARRIER_ON: begin
				p.internal_supply_enable = 1'h1;
				p.carrier_supply_enable  = 1'h1;
			end
			MPUS_ST_RUN: begin
				p.internal_supply_enable = 1'h1;
				p.carrier_supply_enable  = 1'h1;
				p.module_reset_n         = 1'h1;
			end
			MPUS_ST_SUSPEND: begin
				p.internal_supply_enable = 1'h1;
				p.carrier_supply_enable  = 1'h1;
				p.module_reset_n         = 1'h1;
				p.carrier_standby_n      = 1'h0;
			end
		endcase
		return p;
	endfunction

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Fault beats everything, then a supply drop, then the per-state steps
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = '0;
		if (!board_in.input_power_fault_n) begin
			nxt_state = MPUS_ST_OFF;
		end else if (state_ff != MPUS_ST_OFF && !board_in.supplies_good) begin
			// Carrier rails follow the module rails down
			nxt_state = MPUS_ST_SUPPLY_UP;
		end else begin
			unique case (state_ff)
				MPUS_ST_OFF: begin
					nxt_state = MPUS_ST_SUPPLY_UP;
				end
				MPUS_ST_SUPPLY_UP: begin
					nxt_state = MPUS_ST_SOFT_OFF;
				end
				MPUS_ST_SOFT_OFF: begin
					if (press_event || board_in.auto_power_on) begin
						nxt_state = MPUS_ST_CARRIER_ON;
					end
				end
				MPUS_ST_CARRIER_ON: begin
					// Reset stays low until carrier rails had the full settle time
					if (!board_in.reset_request_n) begin
						nxt_cnt = '0;
					end else if (cnt_ff == MPUS_CNT_W'(SETTLE_CYCLES - 1)) begin
						nxt_state = MPUS_ST_RUN;
					end else begin
						nxt_cnt = cnt_ff + MPUS_CNT_W'(1);
					end
				end
				MPUS_ST_RUN: begin
					if (!board_in.reset_request_n) begin
						nxt_state = MPUS_ST_CARRIER_ON;
					end else if (press_event) begin
						nxt_state = MPUS_ST_SOFT_OFF;
					end else if (!board_in.suspend_to_ram_n) begin
						nxt_state = MPUS_ST_SUSPEND;
					end
				end
				MPUS_ST_SUSPEND: begin
					// Wake from suspend is the processor's job; it lifts the request
					if (!board_in.reset_request_n) begin
						nxt_state = MPUS_ST_CARRIER_ON;
					end else if (board_in.suspend_to_ram_n) begin
						nxt_state = MPUS_ST_RUN;
					end
				end
				default: begin
					nxt_state = MPUS_ST_OFF;
				end
			endcase
		end
		nxt_pins = pins_for(nxt_state);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= MPUS_ST_OFF;
			cnt_ff   <= '0;
			pins_ff  <= MPUS_PINS_RESET;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= nxt_cnt;
			pins_ff  <= nxt_pins;
		end
	end

	assign pins = pins_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Counts cycles of carrier power with reset still held
	always_comb begin
		nxt_settle_seen = '0;
		if (pins_ff.carrier_supply_enable && !pins_ff.module_reset_n) begin
			nxt_settle_seen = settle_seen_ff;
			if (settle_seen_ff != '1) begin
				nxt_settle_seen = settle_seen_ff + MPUS_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			settle_seen_ff <= '0;
		end else begin
			settle_seen_ff <= nxt_settle_seen;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_carrier_rise;
		$rose(pins.carrier_supply_enable);
	endsequence

	sequence s_boot_release;
		$rose(pins.module_reset_n) ##0 pins.carrier_supply_enable;
	endsequence

	sequence s_run_reset_request;
		pins.module_reset_n && !board_in.reset_request_n && board_in.input_power_fault_n
			&& board_in.supplies_good;
	endsequence

	property p_wake_cause;
		s_carrier_rise |-> $past(board_in.supplies_good)
			&& $past(press_event || board_in.auto_power_on);
	endproperty

	property p_boot_after_settle;
		s_boot_release |-> settle_seen_ff >= MPUS_CNT_W'(SETTLE_CYCLES);
	endproperty

	a_fault_all_off: assert property (
		!board_in.input_power_fault_n |=> pins == MPUS_PINS_RESET)
		else $error("outputs not off after input power fault");

	a_internal_needs_good: assert property (
		pins.internal_supply_enable |-> $past(board_in.input_power_fault_n))
		else $error("internal supplies on without good input power");

	a_carrier_wake_cause: assert property (p_wake_cause)
		else $error("carrier power rose without supplies and button event");

	a_carrier_needs_internal: assert property (
		pins.carrier_supply_enable |-> pins.internal_supply_enable
			&& $past(board_in.supplies_good))
		else $error("carrier enable without module supplies");

	a_boot_after_settle: assert property (p_boot_after_settle)
		else $error("reset released before carrier settle time");

	a_reset_held_early: assert property (
		!pins.carrier_supply_enable |-> !pins.module_reset_n)
		else $error("reset released before carrier power");

	a_reset_request_taken: assert property (
		s_run_reset_request |=> !pins.module_reset_n ##1 !pins.module_reset_n)
		else $error("reset request did not reset the module");

	a_standby_in_suspend: assert property (
		pins.module_reset_n && pins.carrier_standby_n && !board_in.suspend_to_ram_n
			&& board_in.reset_request_n && board_in.input_power_fault_n
			&& board_in.supplies_good && !press_event
		|=> !pins.carrier_standby_n)
		else $error("standby not driven on suspend request");

	a_button_shutdown: assert property (
		pins.module_reset_n && pins.carrier_standby_n && press_event
			&& board_in.reset_request_n && board_in.supplies_good
			&& board_in.input_power_fault_n
		|=> !pins.carrier_supply_enable && pins.internal_supply_enable)
		else $error("button did not enter soft-off");

	a_standby_only_running: assert property (
		!pins.carrier_standby_n |-> pins.module_reset_n && pins.carrier_supply_enable)
		else $error("standby outside the running state");

endmodule // mpus_sequencer

// file: bench/mpus_carrier_model.sv
module mpus_carrier_model
	import mpus_pkg::*;
#(
	parameter int unsigned IN_SETTLE = 5
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       vin_up,
	input  wire logic [7:0] lag,
	input  wire logic       internal_supply_enable,
	input  wire logic       rail_drop,
	output logic            input_power_fault_n,
	output logic            supplies_good
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] vin_cnt_ff;
	logic [7:0] reg_cnt_ff;

	// ------------------------------------------------------------
	// Input supply qualification
	// ------------------------------------------------------------
	// Fault line held low until the main input has been steady for a while
	always_ff @(posedge clk) begin
		if (rst || !vin_up) begin
			vin_cnt_ff          <= 8'h00;
			input_power_fault_n <= 1'b0;
		end else if (vin_cnt_ff < 8'(IN_SETTLE)) begin
			vin_cnt_ff <= vin_cnt_ff + 8'h01;
		end else begin
			input_power_fault_n <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// On-module regulators
	// ------------------------------------------------------------
	// Slow or prompt by lag; they collapse at once, no soft decay
	always_ff @(posedge clk) begin
		// Rail drop models a regulator that collapses while still enabled
		if (rst || !internal_supply_enable || rail_drop) begin
			reg_cnt_ff    <= 8'h00;
			supplies_good <= 1'b0;
		end else if (reg_cnt_ff < lag) begin
			reg_cnt_ff <= reg_cnt_ff + 8'h01;
		end else begin
			supplies_good <= 1'b1;
		end
	end
endmodule // mpus_carrier_model

// file: bench/mpus_sequencer_tb.sv
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
	$display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
`define WAIT(c, l, nm) begin n = 0; while ((c) !== 1'b1 && n < l) begin @(posedge clk); \
	n++; end if ((c) !== 1'b1) begin err_count++; \
	$display("MISMATCH wait %s exp 1 got 0", nm); test_done(); end end

module mpus_sequencer_tb
	import mpus_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int unsigned DEB = 4;
	localparam int unsigned SET = 8;

	logic           clk;
	logic           rst;
	logic           vin_up;
	logic [7:0]     lag;
	logic           req_n;
	logic           susp_n;
	logic           auto_on;
	logic           btn_n;
	logic           fault_n;
	logic           sgood;
	logic           rail_drop;
	mpus_board_in_t board_in;
	mpus_pins_t     pins;
	int             err_count;
	int             tests_run;
	int             seed;
	int             n;
	int             i;

	assign board_in = '{fault_n, sgood, req_n, susp_n, auto_on};

	mpus_sequencer #(.DEBOUNCE_CYCLES(DEB), .SETTLE_CYCLES(SET)) mpus_sequencer_inst (
		.clk(clk), .rst(rst), .board_in(board_in), .power_button_n(btn_n), .pins(pins));

	mpus_carrier_model mpus_carrier_model_inst (
		.clk(clk), .rst(rst), .vin_up(vin_up), .lag(lag),
		.internal_supply_enable(pins.internal_supply_enable), .rail_drop(rail_drop),
		.input_power_fault_n(fault_n), .supplies_good(sgood));

	always #2.5 clk = ~clk;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic step(input int k);
		repeat (k) @(posedge clk);
	endtask

	// Edges from the start of a wait until released reset shows
	function automatic int unsigned release_wait(input int unsigned lead);
		return SET + lead;
	endfunction

	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Carrier on, then reset release exactly SET cycles later
	task automatic carrier_then_boot();
		`WAIT(pins.carrier_supply_enable, 200, "carrier")
		`CHK("sgood", 1'b1, sgood)
		`CHK("rst_hold", 1'b0, pins.module_reset_n)
		`CHK("stby", 1'b1, pins.carrier_standby_n)
		n = 0;
		while (pins.module_reset_n !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		`CHK("boot", release_wait(0), n)
	endtask

	task automatic power_up();
		`WAIT(pins.internal_supply_enable, 60, "int_en")
		`CHK("early_car", 1'b0, pins.carrier_supply_enable)
		carrier_then_boot();
	endtask

	// Bounces shorter than the window, then a solid press and release
	task automatic press();
		repeat (3) begin
			btn_n <= 1'b0;
			step(1 + ($random(seed) & 32'h0000_0001) + ($random(seed) & 32'h0000_0001));
			btn_n <= 1'b1;
			step(2);
		end
		btn_n <= 1'b0;
		step(DEB + 2);
		btn_n <= 1'b1;
		step(DEB + 2);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		$display("MISMATCH timeout exp 0 got 1");
		test_done();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 55;
		clk = 1'b0;
		rst = 1'b1;
		vin_up = 1'b0;
		lag = 8'h03;
		req_n = 1'b1;
		susp_n = 1'b1;
		auto_on = 1'b1;
		btn_n = 1'b1;
		rail_drop = 1'b0;
		err_count = 0;
		tests_run = 0;
		step(6);
		rst <= 1'b0;
		step(4);
		`CHK("off_int", 1'b0, pins.internal_supply_enable)
		// Input lost at random points of the power-up
		for (i = 0; i < 6; i++) begin
			lag <= 8'($random(seed) & 32'h0000_000F);
			vin_up <= 1'b1;
			step(1 + ($random(seed) & 32'h0000_001F));
			vin_up <= 1'b0;
			step(3);
			`CHK("fault_pins", MPUS_PINS_RESET, pins)
			`CHK("fault_int", 1'b0, pins.internal_supply_enable)
		end
		vin_up <= 1'b1;
		power_up();
		susp_n <= 1'b0;
		step(2);
		`CHK("susp_stby", 1'b0, pins.carrier_standby_n)
		`CHK("susp_car", 1'b1, pins.carrier_supply_enable)
		susp_n <= 1'b1;
		step(2);
		`CHK("wake_stby", 1'b1, pins.carrier_standby_n)
		req_n <= 1'b0;
		step(2);
		`CHK("req_rst", 1'b0, pins.module_reset_n)
		`CHK("req_car", 1'b1, pins.carrier_supply_enable)
		step($random(seed) & 32'h0000_0007);
		req_n <= 1'b1;
		`WAIT(pins.module_reset_n, 20, "reboot")
		`CHK("reboot_len", release_wait(1), n)
		// Reset request taken out of suspend, over a lifted suspend request
		susp_n <= 1'b0;
		step(2);
		`CHK("susp2_stby", 1'b0, pins.carrier_standby_n)
		req_n <= 1'b0;
		susp_n <= 1'b1;
		step(2);
		`CHK("sreq_rst", 1'b0, pins.module_reset_n)
		`CHK("sreq_stby", 1'b1, pins.carrier_standby_n)
		`CHK("sreq_car", 1'b1, pins.carrier_supply_enable)
		req_n <= 1'b1;
		`WAIT(pins.module_reset_n, 20, "sreboot")
		`CHK("sreboot_len", release_wait(1), n)
		// Module rail collapse while running takes carrier power down
		rail_drop <= 1'b1;
		step(3);
		`CHK("drop_car", 1'b0, pins.carrier_supply_enable)
		`CHK("drop_rst", 1'b0, pins.module_reset_n)
		`CHK("drop_int", 1'b1, pins.internal_supply_enable)
		rail_drop <= 1'b0;
		carrier_then_boot();
		auto_on <= 1'b0;
		press();
		`CHK("shut_car", 1'b0, pins.carrier_supply_enable)
		`CHK("shut_rst", 1'b0, pins.module_reset_n)
		`CHK("shut_int", 1'b1, pins.internal_supply_enable)
		press();
		`WAIT(pins.module_reset_n, 30, "wake")
		`CHK("wake_car", 1'b1, pins.carrier_supply_enable)
		// Reset in mid-run, then a full power-up again
		auto_on <= 1'b1;
		rst <= 1'b1;
		step(2);
		`CHK("mid_rst_pins", MPUS_PINS_RESET, pins)
		rst <= 1'b0;
		power_up();
		vin_up <= 1'b0;
		step(3);
		`CHK("end_pins", MPUS_PINS_RESET, pins)
		test_done();
	end
endmodule // mpus_sequencer_tb
